/* logic/dfsr_consts.svh */
// constants for the filter, compensation and status register bank
// assumes byte-wide registers on the control port, 8-bit addresses
//
// What this block does
// - compensation coefficient, 16-bit signed, bytes 25/24
// - coefficient resets zero, zero means no compensation
// - address top bit picks stage one or two
// - address low seven bits pick coefficient index
// - 24-bit value in three bytes stored to memory
// - control bit 2 picks sine or cosine symmetry
// - control bit 1 enables writes, bypasses custom filter
// - control bit 0 picks built-in or custom filter
// - stage two memory 16 deep, 14 mirrored
// - status shows revision, part code, reserved zeros
// - status bit 1 shows automute active
// - status bit 0 shows clock recovery lock
// - pin status shows both pin levels
// - read-only 32-bit sample rate ratio, four bytes
// - ratio latched on lowest byte read, read upward
// - channel status 192 bits at bytes 70..93
// - interpolator bypass skips built-in eight-times filter
`ifndef DFSR_CONSTS_SVH
`define DFSR_CONSTS_SVH

// ****************************************
// register offsets
// ****************************************
`define DFSR_THD_LO 8'h18
`define DFSR_THD_HI 8'h19
`define DFSR_TAP_ADDR 8'h1A
`define DFSR_TAP_B0 8'h1B
`define DFSR_TAP_B1 8'h1C
`define DFSR_TAP_B2 8'h1D
`define DFSR_CTRL 8'h1E
`define DFSR_CHIP_STAT 8'h40
`define DFSR_PIN_STAT 8'h41
`define DFSR_RATIO_B0 8'h42
`define DFSR_RATIO_B1 8'h43
`define DFSR_RATIO_B2 8'h44
`define DFSR_RATIO_B3 8'h45
`define DFSR_CS_FIRST 8'h46
`define DFSR_CS_LAST 8'h5D

// ****************************************
// fields and reset values
// ****************************************
`define DFSR_ADDR_STAGE_BIT 7
`define DFSR_CTRL_SYM_BIT 2
`define DFSR_CTRL_WE_BIT 1
`define DFSR_CTRL_EN_BIT 0
`define DFSR_THD_RESET 16'h0000
`define DFSR_BYTE_RESET 8'h00
`define DFSR_TAP_RESET 24'h000000
`define DFSR_STAGE1_DEPTH 128
`define DFSR_STAGE2_DEPTH 16
`define DFSR_STAGE2_USED 7'h0E
`define DFSR_TAPS_SINE 5'h1B
`define DFSR_TAPS_COSINE 5'h1C

`endif

/* logic/dfsr_pkg.sv */
// types shared by the register bank
// assumes the constants header is included by users for numbers
package dfsr_pkg;
    // coefficient word stored in filter memory
    typedef logic [23:0] dfsr_coef_type;
    // which oversampling stage an access targets
    typedef enum logic {dfsr_stage_one, dfsr_stage_two} dfsr_stage_type;
endpackage

/* logic/dfsr_regs.sv */
// register bank: harmonic compensation, custom filter memory, status readback
// assumes a byte-wide register port already decoded from the control bus,
// status inputs synchronous to mclk_in
`timescale 1ns/1ps
`include "dfsr_consts.svh"

module dfsr_regs #(
    parameter int STAGE1_DEPTH = `DFSR_STAGE1_DEPTH,
    parameter int STAGE2_DEPTH = `DFSR_STAGE2_DEPTH,
    parameter logic [2:0] PART_CODE = 3'h2 // arbitrary value
) (
    // clock and reset
    input wire logic mclk_in,
    input wire logic rstn_in,
    // register port
    input wire logic [7:0] reg_addr_in,
    input wire logic reg_wr_in,
    input wire logic [7:0] reg_wdata_in,
    input wire logic reg_rd_in,
    output logic [7:0] reg_rdata_out,
    // device status inputs
    input wire logic revision_in,
    input wire logic automute_in,
    input wire logic lock_in,
    input wire logic [1:0] gpio_level_in,
    input wire logic [31:0] ratio_in,
    input wire logic [191:0] chan_status_in,
    input wire logic osf_bypass_in,
    // filter datapath side
    input wire logic coef_rd_stage_in,
    input wire logic [6:0] coef_rd_tap_in,
    output dfsr_pkg::dfsr_coef_type coef_rd_data_out,
    output logic [15:0] third_harmonic_coefficient_out,
    output logic thd_comp_active_out,
    output logic custom_filter_active_out,
    output logic builtin_fir_bypass_out,
    output logic second_stage_symmetry_out,
    output logic [4:0] stage2_taps_out
);

    // ****************************************
    // storage
    // ****************************************
    logic [15:0] third_harmonic_coefficient;
    logic [7:0] filter_tap_address;
    dfsr_pkg::dfsr_coef_type filter_tap_value;
    logic [7:0] filter_control;
    logic [31:0] ratio_latched;
    // no reset on the memories: contents are undefined until loaded
    dfsr_pkg::dfsr_coef_type stage1_mem [STAGE1_DEPTH];
    dfsr_pkg::dfsr_coef_type stage2_mem [STAGE2_DEPTH];

    // maps a stage two tap onto the stored half response
    function automatic logic [3:0] dfsr_mirror(input logic [6:0] tap, input logic cosine);
        logic [6:0] idx;
        idx = tap;
        if (tap >= `DFSR_STAGE2_USED) begin
            idx = cosine ? 7'(7'd27 - tap) : 7'(7'd26 - tap);
        end
        return idx[3:0];
    endfunction

    // ****************************************
    // decode
    // ****************************************
    // write hits per register
    wire wr_thd_lo = reg_wr_in && (reg_addr_in == `DFSR_THD_LO);
    wire wr_thd_hi = reg_wr_in && (reg_addr_in == `DFSR_THD_HI);
    wire wr_addr = reg_wr_in && (reg_addr_in == `DFSR_TAP_ADDR);
    wire wr_b0 = reg_wr_in && (reg_addr_in == `DFSR_TAP_B0);
    wire wr_b1 = reg_wr_in && (reg_addr_in == `DFSR_TAP_B1);
    wire wr_b2 = reg_wr_in && (reg_addr_in == `DFSR_TAP_B2);
    wire wr_ctrl = reg_wr_in && (reg_addr_in == `DFSR_CTRL);
    wire rd_ratio0 = reg_rd_in && (reg_addr_in == `DFSR_RATIO_B0);

    // commit only on the top byte so half-written values never land
    wire we_bit = filter_control[`DFSR_CTRL_WE_BIT];
    wire mem_wr = wr_b2 && we_bit;
    wire [23:0] commit_word = {reg_wdata_in, filter_tap_value[15:0]};
    wire wr_stage2 = filter_tap_address[`DFSR_ADDR_STAGE_BIT];
    wire [6:0] wr_index = filter_tap_address[6:0];

    // channel status byte select, lowest byte at the first offset
    wire cs_hit = (reg_addr_in >= `DFSR_CS_FIRST) && (reg_addr_in <= `DFSR_CS_LAST);
    wire [4:0] cs_idx = 5'(reg_addr_in - `DFSR_CS_FIRST);
    wire [7:0] cs_byte = chan_status_in[cs_idx * 8 +: 8];

    // status words, reserved bits read zero
    wire [7:0] chip_status = {2'h0, revision_in, PART_CODE, automute_in, lock_in};
    wire [7:0] pin_level_status = {6'h00, gpio_level_in};

    // ****************************************
    // read mux
    // ****************************************
    logic [7:0] next_rdata;
    always_comb begin
        next_rdata = 8'h00;
        case (reg_addr_in)
            `DFSR_THD_LO: next_rdata = third_harmonic_coefficient[7:0];
            `DFSR_THD_HI: next_rdata = third_harmonic_coefficient[15:8];
            `DFSR_TAP_ADDR: next_rdata = filter_tap_address;
            `DFSR_TAP_B0: next_rdata = filter_tap_value[7:0];
            `DFSR_TAP_B1: next_rdata = filter_tap_value[15:8];
            `DFSR_TAP_B2: next_rdata = filter_tap_value[23:16];
            `DFSR_CTRL: next_rdata = filter_control;
            `DFSR_CHIP_STAT: next_rdata = chip_status;
            `DFSR_PIN_STAT: next_rdata = pin_level_status;
            // lowest byte comes live, the same value that gets latched
            `DFSR_RATIO_B0: next_rdata = ratio_in[7:0];
            `DFSR_RATIO_B1: next_rdata = ratio_latched[15:8];
            `DFSR_RATIO_B2: next_rdata = ratio_latched[23:16];
            `DFSR_RATIO_B3: next_rdata = ratio_latched[31:24];
            default: next_rdata = cs_hit ? cs_byte : 8'h00;
        endcase
    end

    // ****************************************
    // filter read side
    // ****************************************
    // stage two taps beyond the stored half are mirrored back
    wire [3:0] s2_idx = dfsr_mirror(coef_rd_tap_in, filter_control[`DFSR_CTRL_SYM_BIT]);
    wire [23:0] rd_word = coef_rd_stage_in ? stage2_mem[s2_idx] : stage1_mem[coef_rd_tap_in];
    // custom filter is out of the path while writes are open
    wire next_custom = filter_control[`DFSR_CTRL_EN_BIT] && !we_bit;
    wire next_sym = filter_control[`DFSR_CTRL_SYM_BIT];
    wire [4:0] next_taps = next_sym ? `DFSR_TAPS_COSINE : `DFSR_TAPS_SINE;

    // ****************************************
    // registers
    // ****************************************
    // host-written registers
    always_ff @(posedge mclk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            third_harmonic_coefficient <= `DFSR_THD_RESET;
            filter_tap_address <= `DFSR_BYTE_RESET;
            filter_tap_value <= `DFSR_TAP_RESET;
            filter_control <= `DFSR_BYTE_RESET;
        end else begin
            if (wr_thd_lo) third_harmonic_coefficient[7:0] <= reg_wdata_in;
            if (wr_thd_hi) third_harmonic_coefficient[15:8] <= reg_wdata_in;
            if (wr_addr) filter_tap_address <= reg_wdata_in;
            if (wr_b0) filter_tap_value[7:0] <= reg_wdata_in;
            if (wr_b1) filter_tap_value[15:8] <= reg_wdata_in;
            if (wr_b2) filter_tap_value[23:16] <= reg_wdata_in;
            if (wr_ctrl) filter_control <= reg_wdata_in;
        end
    end

    // ratio snapshot so the upper bytes match the low byte read
    always_ff @(posedge mclk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            ratio_latched <= 32'h00000000;
        end else if (rd_ratio0) begin
            ratio_latched <= ratio_in;
        end
    end

    // coefficient memories
    always_ff @(posedge mclk_in) begin
        if (mem_wr && !wr_stage2) begin
            stage1_mem[wr_index] <= commit_word;
        end
        if (mem_wr && wr_stage2) begin
            stage2_mem[wr_index[3:0]] <= commit_word;
        end
    end

    // registered outputs
    always_ff @(posedge mclk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            reg_rdata_out <= 8'h00;
            coef_rd_data_out <= `DFSR_TAP_RESET;
            third_harmonic_coefficient_out <= `DFSR_THD_RESET;
            thd_comp_active_out <= 1'b0;
            custom_filter_active_out <= 1'b0;
            builtin_fir_bypass_out <= 1'b0;
            second_stage_symmetry_out <= 1'b0;
            stage2_taps_out <= `DFSR_TAPS_SINE;
        end else begin
            if (reg_rd_in) reg_rdata_out <= next_rdata;
            coef_rd_data_out <= rd_word;
            third_harmonic_coefficient_out <= third_harmonic_coefficient;
            thd_comp_active_out <= |third_harmonic_coefficient;
            custom_filter_active_out <= next_custom;
            builtin_fir_bypass_out <= osf_bypass_in;
            second_stage_symmetry_out <= next_sym;
            stage2_taps_out <= next_taps;
        end
    end

    // ****************************************
    // checks
    // ****************************************
    property p_thd_high;
        @(posedge mclk_in) disable iff (!rstn_in)
        wr_thd_hi |=> ##1 third_harmonic_coefficient_out[15:8] == $past(reg_wdata_in, 2);
    endproperty
    a_thd_high: assert property (p_thd_high)
        else $error("compensation upper byte not applied");

    property p_thd_zero;
        @(posedge mclk_in) disable iff (!rstn_in)
        (third_harmonic_coefficient_out == 16'h0000) |-> !thd_comp_active_out;
    endproperty
    a_thd_zero: assert property (p_thd_zero)
        else $error("compensation active with zero coefficient");

    property p_no_commit;
        @(posedge mclk_in) disable iff (!rstn_in)
        (wr_b0 || wr_b1 || (wr_b2 && !we_bit)) |-> !mem_wr;
    endproperty
    a_no_commit: assert property (p_no_commit)
        else $error("coefficient committed without enabled top byte");

    property p_commit;
        @(posedge mclk_in) disable iff (!rstn_in)
        (wr_b2 && filter_control[1]) |-> mem_wr && commit_word[23:16] == reg_wdata_in;
    endproperty
    a_commit: assert property (p_commit)
        else $error("enabled top byte write did not commit");

    property p_custom;
        @(posedge mclk_in) disable iff (!rstn_in)
        custom_filter_active_out |-> $past(filter_control[0]) && !$past(filter_control[1]);
    endproperty
    a_custom: assert property (p_custom)
        else $error("custom filter active while writes open or not chosen");

    property p_taps;
        @(posedge mclk_in) disable iff (!rstn_in)
        wr_ctrl ##1 !wr_ctrl |=> stage2_taps_out == ($past(reg_wdata_in[2], 2) ? 5'h1C : 5'h1B);
    endproperty
    a_taps: assert property (p_taps)
        else $error("stage two tap count wrong for symmetry");

    property p_ratio;
        @(posedge mclk_in) disable iff (!rstn_in)
        rd_ratio0 |=> ratio_latched == $past(ratio_in) && reg_rdata_out == $past(ratio_in[7:0]);
    endproperty
    a_ratio: assert property (p_ratio)
        else $error("ratio not captured on low byte read");

    property p_chip;
        @(posedge mclk_in) disable iff (!rstn_in)
        (reg_rd_in && reg_addr_in == 8'h40) |=>
            reg_rdata_out == {2'h0, $past(revision_in), PART_CODE, $past(automute_in), $past(lock_in)};
    endproperty
    a_chip: assert property (p_chip)
        else $error("chip status readback wrong");

    property p_pins;
        @(posedge mclk_in) disable iff (!rstn_in)
        (reg_rd_in && reg_addr_in == 8'h41) |=> reg_rdata_out == {6'h00, $past(gpio_level_in)};
    endproperty
    a_pins: assert property (p_pins)
        else $error("pin status readback wrong");

    property p_cs_top;
        @(posedge mclk_in) disable iff (!rstn_in)
        (reg_rd_in && reg_addr_in == 8'h5D) |=> reg_rdata_out == $past(chan_status_in[191:184]);
    endproperty
    a_cs_top: assert property (p_cs_top)
        else $error("channel status top byte wrong");

    property p_thd_low;
        @(posedge mclk_in) disable iff (!rstn_in)
        wr_thd_lo |=> ##1 third_harmonic_coefficient_out[7:0] == $past(reg_wdata_in, 2);
    endproperty
    a_thd_low: assert property (p_thd_low)
        else $error("compensation lower byte not applied");

    property p_thd_active;
        @(posedge mclk_in) disable iff (!rstn_in)
        (wr_thd_lo || wr_thd_hi) |=> ##1
            thd_comp_active_out == ($past(third_harmonic_coefficient) != 16'h0000);
    endproperty
    a_thd_active: assert property (p_thd_active)
        else $error("compensation active flag wrong");

    property p_tap_addr;
        @(posedge mclk_in) disable iff (!rstn_in)
        wr_addr |=> filter_tap_address == $past(reg_wdata_in);
    endproperty
    a_tap_addr: assert property (p_tap_addr)
        else $error("filter address not stored");

    property p_stage1_store;
        @(posedge mclk_in) disable iff (!rstn_in)
        (mem_wr && !wr_stage2) |=> stage1_mem[$past(wr_index)] == $past(commit_word);
    endproperty
    a_stage1_store: assert property (p_stage1_store)
        else $error("stage one word not stored");

    property p_stage2_store;
        @(posedge mclk_in) disable iff (!rstn_in)
        (mem_wr && wr_stage2) |=> stage2_mem[$past(wr_index[3:0])] == $past(commit_word);
    endproperty
    a_stage2_store: assert property (p_stage2_store)
        else $error("stage two word not stored");

    property p_sym;
        @(posedge mclk_in) disable iff (!rstn_in)
        wr_ctrl |=> ##1 second_stage_symmetry_out == $past(reg_wdata_in[2], 2);
    endproperty
    a_sym: assert property (p_sym)
        else $error("symmetry output does not follow control");

    property p_custom_sel;
        @(posedge mclk_in) disable iff (!rstn_in)
        wr_ctrl |=> ##1
            custom_filter_active_out == ($past(reg_wdata_in[0], 2) && !$past(reg_wdata_in[1], 2));
    endproperty
    a_custom_sel: assert property (p_custom_sel)
        else $error("custom filter selection wrong");

    property p_we_bypass;
        @(posedge mclk_in) disable iff (!rstn_in)
        (wr_ctrl && reg_wdata_in[`DFSR_CTRL_WE_BIT]) |=> ##1 !custom_filter_active_out;
    endproperty
    a_we_bypass: assert property (p_we_bypass)
        else $error("custom filter in use while writes open");

    property p_bypass;
        @(posedge mclk_in) disable iff (!rstn_in)
        1'b1 |=> builtin_fir_bypass_out == $past(osf_bypass_in);
    endproperty
    a_bypass: assert property (p_bypass)
        else $error("interpolator bypass not followed");

    property p_cs_low;
        @(posedge mclk_in) disable iff (!rstn_in)
        (reg_rd_in && reg_addr_in == 8'h46) |=> reg_rdata_out == $past(chan_status_in[7:0]);
    endproperty
    a_cs_low: assert property (p_cs_low)
        else $error("channel status low byte wrong");

    property p_ratio_top;
        @(posedge mclk_in) disable iff (!rstn_in)
        (reg_rd_in && reg_addr_in == 8'h45) |=> reg_rdata_out == $past(ratio_latched[31:24]);
    endproperty
    a_ratio_top: assert property (p_ratio_top)
        else $error("ratio top byte not from snapshot");

endmodule

/* dv/dfsr_host_model.sv */
// host controller model driving the byte-wide register port of the bank
// assumes the bench calls its tasks from one process, one request at a time
`timescale 1ns/1ps
`include "dfsr_consts.svh"

module dfsr_host_model (
    // clock
    input wire logic mclk_in,
    // register port
    output logic [7:0] reg_addr_out,
    output logic reg_wr_out,
    output logic [7:0] reg_wdata_out,
    output logic reg_rd_out,
    input wire logic [7:0] reg_rdata_in
);
    // ****************************************
    // idle port and request tasks
    // ****************************************
    // known idle levels at time zero
    initial begin
        reg_addr_out = 8'h00;
        reg_wr_out = 1'b0;
        reg_wdata_out = 8'h00;
        reg_rd_out = 1'b0;
    end

    // released lines show the inverse so a stale value never passes
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk_in);
        reg_addr_out <= a;
        reg_wdata_out <= d;
        reg_wr_out <= 1'b1;
        @(posedge mclk_in);
        reg_wr_out <= 1'b0;
        reg_addr_out <= ~a;
        reg_wdata_out <= ~d;
    endtask

    // data taken just after the edge that follows the strobe
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge mclk_in);
        reg_addr_out <= a;
        reg_rd_out <= 1'b1;
        @(posedge mclk_in);
        reg_rd_out <= 1'b0;
        reg_addr_out <= ~a;
        #1 d = reg_rdata_in;
    endtask

    // coarse byte first, then fine byte
    task automatic thd(input logic [15:0] v);
        wr(`DFSR_THD_HI, v[15:8]);
        wr(`DFSR_THD_LO, v[7:0]);
    endtask

    // reserved control bits always written as zero
    task automatic ctrl(input logic [2:0] v);
        wr(`DFSR_CTRL, {5'h00, v});
    endtask

    // value bytes low to high, top byte commits while writes are enabled
    task automatic coef(input logic [7:0] addr, input logic [23:0] v, input logic we);
        wr(`DFSR_TAP_ADDR, addr);
        ctrl({1'b0, we, 1'b0});
        wr(`DFSR_TAP_B0, v[7:0]);
        wr(`DFSR_TAP_B1, v[15:8]);
        wr(`DFSR_TAP_B2, v[23:16]);
        ctrl(3'h0);
    endtask
endmodule

/* dv/dfsr_regs_tb.sv */
// self-checking bench for the filter, compensation and status register bank
// assumes the host model above drives the register port
`timescale 1ns/1ps
`include "dfsr_consts.svh"

module dfsr_regs_tb;
    localparam logic [2:0] PART = 3'h5; // arbitrary value
    logic mclk_in = 1'b0;
    logic rstn_in = 1'b0;
    logic [7:0] reg_addr_in, reg_wdata_in, reg_rdata_out, rv;
    logic reg_wr_in, reg_rd_in, thd_act, cust_act, fir_byp, sym;
    logic revision_in = 1'b0, automute_in = 1'b0, lock_in = 1'b0;
    logic osf_bypass_in = 1'b0, coef_rd_stage_in = 1'b0;
    logic [1:0] gpio_level_in = 2'h0;
    logic [31:0] ratio_in = 32'h0, r32;
    logic [191:0] chan_status_in = '0;
    logic [6:0] coef_rd_tap_in = 7'h00;
    dfsr_pkg::dfsr_coef_type coef_rd_data_out;
    logic [15:0] thd_out;
    logic [4:0] taps;
    logic [23:0] w1, w2, w3;
    int err_total = 0;
    int checks = 0;

    // ****************************************
    // clock, design, host
    // ****************************************
    // 100 MHz clock
    always #5 mclk_in = ~mclk_in;

    dfsr_regs #(.PART_CODE(PART)) uut (.mclk_in(mclk_in), .rstn_in(rstn_in),
        .reg_addr_in(reg_addr_in), .reg_wr_in(reg_wr_in), .reg_wdata_in(reg_wdata_in),
        .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out), .revision_in(revision_in),
        .automute_in(automute_in), .lock_in(lock_in), .gpio_level_in(gpio_level_in),
        .ratio_in(ratio_in), .chan_status_in(chan_status_in), .osf_bypass_in(osf_bypass_in),
        .coef_rd_stage_in(coef_rd_stage_in), .coef_rd_tap_in(coef_rd_tap_in),
        .coef_rd_data_out(coef_rd_data_out), .third_harmonic_coefficient_out(thd_out),
        .thd_comp_active_out(thd_act), .custom_filter_active_out(cust_act),
        .builtin_fir_bypass_out(fir_byp), .second_stage_symmetry_out(sym),
        .stage2_taps_out(taps));

    dfsr_host_model host (.mclk_in(mclk_in), .reg_addr_out(reg_addr_in),
        .reg_wr_out(reg_wr_in), .reg_wdata_out(reg_wdata_in), .reg_rd_out(reg_rd_in),
        .reg_rdata_in(reg_rdata_out));

    // ****************************************
    // checking helpers
    // ****************************************
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        checks++;
        if (got !== exp) begin
            err_total++;
            $display("[FAIL] %0t ns %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    task automatic close_out();
        $display("checks %0d mismatches %0d", checks, err_total);
        if (err_total == 0 && checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // registered outputs trail the strobe by two edges
    task automatic settle();
        repeat (2) @(posedge mclk_in);
        #1;
    endtask

    // filter-side read, answer one edge later
    task automatic coef_chk(input logic st, input logic [6:0] t, input logic [23:0] e);
        @(posedge mclk_in);
        coef_rd_stage_in <= st;
        coef_rd_tap_in <= t;
        @(posedge mclk_in);
        #1 chk(32'(coef_rd_data_out), 32'(e), "coef word");
    endtask

    // second stage taps beyond the stored half fold back onto it
    function automatic logic [6:0] fold(input logic cos_sym, input logic [6:0] t);
        return (t < 7'h0E) ? t : (cos_sym ? 7'h1B - t : 7'h1A - t);
    endfunction

    // word loaded at each of the three stored stage two locations used
    function automatic logic [23:0] s2_exp(input logic [6:0] i);
        return (i == 7'h0C) ? w1 : ((i == 7'h0D) ? w2 : w3);
    endfunction

    function automatic logic [7:0] chip_exp(input logic r, input logic m, input logic k);
        return {2'h0, r, PART, m, k};
    endfunction

    // ****************************************
    // tests
    // ****************************************
    // watchdog, far beyond the few hundred cycles the tests take
    initial begin
        #200000;
        err_total++;
        close_out();
    end

    // main sequence
    initial begin
        void'($urandom(48167));
        repeat (10) @(posedge mclk_in);
        rstn_in <= 1'b1;
        for (int a = 24; a <= 30; a++) begin
            host.rd(8'(a), rv);
            chk(32'(rv), 32'h0, "reset value");
        end
        chk(32'(taps), 32'd27, "reset taps");
        chk(32'(fir_byp), 32'h0, "reset bypass");
        $display("test reset done");
        r32 = $urandom;
        host.thd(r32[15:0]);
        settle();
        chk(32'(thd_out), 32'(r32[15:0]), "thd out");
        chk(32'(thd_act), 32'(r32[15:0] != 16'h0000), "thd active");
        host.rd(`DFSR_THD_LO, rv);
        chk(32'(rv), 32'(r32[7:0]), "thd low");
        host.rd(`DFSR_THD_HI, rv);
        chk(32'(rv), 32'(r32[15:8]), "thd high");
        host.thd(16'h0000);
        settle();
        chk(32'(thd_act), 32'h0, "thd zero");
        $display("test compensation done");
        for (int c = 0; c < 8; c++) begin
            host.ctrl(3'(c));
            settle();
            chk(32'(sym), 32'(c[2]), "symmetry");
            chk(32'(taps), c[2] ? 32'd28 : 32'd27, "taps");
            chk(32'(cust_act), 32'(c[0] & ~c[1]), "custom active");
            host.rd(`DFSR_CTRL, rv);
            chk(32'(rv), 32'(c), "ctrl readback");
        end
        $display("test control done");
        w1 = 24'($urandom);
        w2 = ~w1;
        w3 = w1 ^ 24'h5A5A5A;
        r32 = $urandom_range(127, 0);
        host.coef({1'b0, r32[6:0]}, w1, 1'b1);
        host.coef({1'b0, r32[6:0]}, w2, 1'b0);
        coef_chk(1'b0, r32[6:0], w1);
        host.rd(`DFSR_TAP_B2, rv);
        chk(32'(rv), 32'(w2[23:16]), "value readback");
        host.coef(8'h8C, w1, 1'b1);
        host.coef(8'h8D, w2, 1'b1);
        host.coef(8'h8B, w3, 1'b1);
        for (int s = 0; s < 2; s++) begin
            host.ctrl({s[0], 2'h0});
            settle();
            for (int t = 12; t < 16; t++) begin
                coef_chk(1'b1, 7'(t), s2_exp(fold(s[0], 7'(t))));
            end
        end
        $display("test coefficients done");
        for (int i = 0; i < 4; i++) begin
            @(posedge mclk_in);
            {revision_in, automute_in, lock_in, gpio_level_in} <= 5'($urandom);
            host.rd(`DFSR_CHIP_STAT, rv);
            chk(32'(rv), 32'(chip_exp(revision_in, automute_in, lock_in)), "chip");
            host.rd(`DFSR_PIN_STAT, rv);
            chk(32'(rv), {30'h0, gpio_level_in}, "pins");
        end
        host.wr(`DFSR_CHIP_STAT, 8'hFF);
        host.rd(8'h10, rv);
        chk(32'(rv), 32'h0, "unmapped");
        $display("test status done");
        r32 = $urandom;
        @(posedge mclk_in);
        ratio_in <= r32;
        host.rd(`DFSR_RATIO_B0, rv);
        chk(32'(rv), 32'(r32[7:0]), "ratio low");
        @(posedge mclk_in);
        ratio_in <= ~r32;
        for (int b = 1; b < 4; b++) begin
            host.rd(8'(`DFSR_RATIO_B0 + b), rv);
            chk(32'(rv), 32'(r32[8*b +: 8]), "ratio latched");
        end
        @(posedge mclk_in);
        for (int i = 0; i < 6; i++) begin
            chan_status_in[32*i +: 32] <= $urandom;
        end
        for (int b = 0; b < 24; b++) begin
            host.rd(8'(`DFSR_CS_FIRST + b), rv);
            chk(32'(rv), 32'(chan_status_in[8*b +: 8]), "channel status");
        end
        @(posedge mclk_in);
        osf_bypass_in <= 1'b1;
        settle();
        chk(32'(fir_byp), 32'h1, "bypass");
        $display("test readback done");
        close_out();
    end
endmodule
